// >>> verilog/pmc_status_bank.sv
/*
  Performance counter and block summary bank: clear-on-read zero
  violation counter with a held low byte, two frame check error counters,
  the clock-loss enable register and the block interrupt summary byte.
  Assumes event inputs come from framer logic on the same clock as
  one-cycle pulses or levels, and a host that issues single-cycle read
  and write strobes with a stable address.
*/
`timescale 1ns/1ps

module pmc_status_bank
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // microprocessor port
  input wire logic [ADDR_W-1:0] mp_addr_i,
  input wire logic mp_rd_i,
  input wire logic mp_wr_i,
  input wire logic [DATA_W-1:0] mp_wdata_i,
  output logic [DATA_W-1:0] mp_rdata_o,
  output logic mp_rvalid_o,
  // performance monitor events
  input wire logic zero_violation_i,
  input wire logic link2_fcs_error_i,
  input wire logic link3_fcs_error_i,
  // block request sources
  input wire logic loopback_code_req_i,
  input wire logic recovered_clock_lost_i,
  input wire logic one_second_tick_i,
  input wire logic [NUM_LINK_SRC-1:0] link_req_i,
  input wire logic slip_req_i,
  // configuration
  output logic clk_loss_detect_en_o
);

  // counter carriers
  pmc_cnt_if #(.W(ZV_W)) zv_if ();
  pmc_cnt_if #(.W(FCS_W)) fcs2_if ();
  pmc_cnt_if #(.W(FCS_W)) fcs3_if ();

  // address decode of the current strobe
  logic rd_zv_high;
  logic rd_zv_low;
  logic rd_fcs2;
  logic rd_fcs3;
  logic rd_sum;
  logic rd_cfg;
  logic wr_cfg;
  logic rd_loop_src;
  logic rd_slip_src;
  logic [NUM_LINK_SRC-1:0] rd_link_src;

  // holding register state
  logic [7:0] zv_hold_ff;
  logic zv_hold_vld_ff;
  logic [7:0] nxt_zv_hold;
  logic nxt_zv_hold_vld;

  // configuration and read port state
  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // pending flags and summary byte
  logic loop_pend;
  logic slip_pend;
  logic [NUM_LINK_SRC-1:0] link_pend;
  logic clk_los_en;
  logic [7:0] summary;

  // strobe decode
  always_comb begin
    rd_zv_high = mp_rd_i && (mp_addr_i == ADDR_ZV_HIGH);
    rd_zv_low = mp_rd_i && (mp_addr_i == ADDR_ZV_LOW);
    rd_fcs2 = mp_rd_i && (mp_addr_i == ADDR_LINK2_FCS);
    rd_fcs3 = mp_rd_i && (mp_addr_i == ADDR_LINK3_FCS);
    rd_sum = mp_rd_i && (mp_addr_i == ADDR_BLOCK_SUM);
    rd_cfg = mp_rd_i && (mp_addr_i == ADDR_CLK_CFG);
    wr_cfg = mp_wr_i && (mp_addr_i == ADDR_CLK_CFG);
    rd_loop_src = mp_rd_i && (mp_addr_i == ADDR_LOOP_SRC);
    rd_slip_src = mp_rd_i && (mp_addr_i == ADDR_SLIP_SRC);
    rd_link_src = mp_rd_i ? link_src_hit(mp_addr_i) : '0;
  end

  always_comb begin
    zv_if.evt = zero_violation_i;
    zv_if.clr = rd_zv_high || (rd_zv_low && !zv_hold_vld_ff);
    fcs2_if.evt = link2_fcs_error_i;
    fcs3_if.evt = link3_fcs_error_i;
  end

  always_comb begin
    fcs2_if.clr = rd_fcs2;
    fcs3_if.clr = rd_fcs3;
  end

  // zero violation counter, 16 bits
  pmc_rc_count #(.W(ZV_W)) u_zv_count (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .cnt_io(zv_if.cnt_mp)
  );

  // link 2 frame check error counter
  pmc_rc_count #(.W(FCS_W)) u_fcs2_count (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .cnt_io(fcs2_if.cnt_mp)
  );

  // link 3 frame check error counter
  pmc_rc_count #(.W(FCS_W)) u_fcs3_count (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .cnt_io(fcs3_if.cnt_mp)
  );

  // capture low byte on upper read
  always_comb begin
    nxt_zv_hold = zv_hold_ff;
    nxt_zv_hold_vld = zv_hold_vld_ff;
    if (rd_zv_high) begin
      nxt_zv_hold = zv_if.cnt[7:0];
      nxt_zv_hold_vld = 1'b1;
    end else if (rd_zv_low) begin
      nxt_zv_hold_vld = 1'b0;
    end
  end

  // holding register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      zv_hold_ff <= RST_BYTE;
      zv_hold_vld_ff <= 1'b0;
    end else begin
      zv_hold_ff <= nxt_zv_hold;
      zv_hold_vld_ff <= nxt_zv_hold_vld;
    end
  end

  // loopback flag retires on its source read
  // each data-link flag retires on its own read
  // slip flag retires on its source read
  pmc_pend_flags #(.N(NUM_LINK_SRC + 2)) u_pend (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .set_i({loopback_code_req_i, slip_req_i, link_req_i}),
    .clr_i({rd_loop_src, rd_slip_src, rd_link_src}),
    .pend_o({loop_pend, slip_pend, link_pend})
  );

  // configuration register write
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_cfg) begin
      nxt_cfg = mp_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_ff <= RST_BYTE;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign clk_los_en = cfg_ff[BIT_CLKLOS_EN];

  // summary byte assembly
  always_comb begin
    summary = RST_BYTE;
    summary[BIT_LOOP] = loop_pend;
    summary[BIT_CLKLOS] = recovered_clock_lost_i && clk_los_en;
    summary[BIT_ONE_SECOND_TICK] = one_second_tick_i;
    summary[BIT_LINK] = |link_pend;
    summary[BIT_SLIP] = slip_pend;
  end

  // read data select, registered one cycle after the strobe
  always_comb begin
    nxt_rvalid = mp_rd_i;
    nxt_rdata = rdata_ff;
    if (mp_rd_i) begin
      case (mp_addr_i)
        ADDR_ZV_HIGH: nxt_rdata = zv_if.cnt[15:8];
        // low byte, held after upper read
        ADDR_ZV_LOW: nxt_rdata = zv_hold_vld_ff ? zv_hold_ff : zv_if.cnt[7:0];
        ADDR_LINK2_FCS: nxt_rdata = fcs2_if.cnt;
        ADDR_LINK3_FCS: nxt_rdata = fcs3_if.cnt;
        ADDR_BLOCK_SUM: nxt_rdata = summary;
        ADDR_CLK_CFG: nxt_rdata = cfg_ff;
        default: nxt_rdata = RD_UNMAPPED;
      endcase
    end
  end

  // read port registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= RST_BYTE;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign mp_rdata_o = rdata_ff;
  assign mp_rvalid_o = rvalid_ff;
  assign clk_loss_detect_en_o = cfg_ff[BIT_CLKLOS_EN];

  // checks on counting, holding and summary behaviour

  property p_zv_inc;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (zero_violation_i && !zv_if.clr && (zv_if.cnt != 16'hFFFF))
      |=> (zv_if.cnt == $past(zv_if.cnt) + 16'h0001);
  endproperty
  a_zv_inc: assert property (p_zv_inc) else $error("violation count did not step");

  property p_zv_hold;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_zv_high && !zero_violation_i)
      |=> (zv_hold_vld_ff && (zv_hold_ff == $past(zv_if.cnt[7:0])) && (zv_if.cnt == 16'h0000));
  endproperty
  a_zv_hold: assert property (p_zv_hold) else $error("upper read did not hold and restart");

  property p_zv_pair;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_zv_high && !zero_violation_i) ##1 (!mp_rd_i && !zero_violation_i)
      ##1 (rd_zv_low && !zero_violation_i)
      |=> (mp_rdata_o == $past(zv_hold_ff)) ##1 (zv_if.cnt == 16'h0000);
  endproperty
  a_zv_pair: assert property (p_zv_pair) else $error("ordered pair read gave wrong low byte");

  property p_zv_high_data;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    rd_zv_high |=> (mp_rvalid_o && (mp_rdata_o == $past(zv_if.cnt[15:8])));
  endproperty
  a_zv_high_data: assert property (p_zv_high_data) else $error("upper byte read wrong");

  property p_fcs2_clear;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_fcs2 && !link2_fcs_error_i) |=> (fcs2_if.cnt == 8'h00)
      && (mp_rdata_o == $past(fcs2_if.cnt));
  endproperty
  a_fcs2_clear: assert property (p_fcs2_clear) else $error("link 2 count not cleared on read");

  property p_fcs3_clear;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_fcs3 && link3_fcs_error_i) |=> (fcs3_if.cnt == 8'h01);
  endproperty
  a_fcs3_clear: assert property (p_fcs3_clear) else $error("link 3 event lost at clear");

  property p_loop_pend;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    loopback_code_req_i ##1 (rd_sum && !rd_loop_src) |=> mp_rdata_o[BIT_LOOP];
  endproperty
  a_loop_pend: assert property (p_loop_pend) else $error("loopback request not shown");

  property p_loop_clear;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (rd_loop_src && !loopback_code_req_i) |=> !loop_pend;
  endproperty
  a_loop_clear: assert property (p_loop_clear) else $error("loopback flag not retired");

  property p_clklos_gate;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    rd_sum |=> (mp_rdata_o[BIT_CLKLOS] == $past(recovered_clock_lost_i && clk_los_en))
      && (mp_rdata_o[BIT_ONE_SECOND_TICK] == $past(one_second_tick_i));
  endproperty
  a_clklos_gate: assert property (p_clklos_gate) else $error("clock loss or second bit wrong");

  property p_link_clear;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (link_req_i[0] && !(|link_pend[NUM_LINK_SRC-1:1])) ##1 (rd_link_src[0] && !(|link_req_i))
      |-> summary[BIT_LINK] ##1 !summary[BIT_LINK];
  endproperty
  a_link_clear: assert property (p_link_clear) else $error("data-link summary not retired");

  property p_slip;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (slip_req_i && rd_slip_src) |=> summary[BIT_SLIP];
  endproperty
  a_slip: assert property (p_slip) else $error("slip request lost at clear");

endmodule

// >>> verilog/pmc_pkg.sv
/*
  Constants for the performance counter and block summary bank: register
  addresses, summary bit positions, widths and reset values.
  Assumes an 8-bit microprocessor data path with 16-bit byte addresses.
*/
package pmc_pkg;

  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // counter widths
  localparam int ZV_W = 16;
  localparam int FCS_W = 8;

  // number of data-link source status registers
  localparam int NUM_LINK_SRC = 6;

  // register addresses owned by this bank
  localparam logic [15:0] ADDR_ZV_HIGH = 16'h0911;
  localparam logic [15:0] ADDR_ZV_LOW = 16'h0912;
  localparam logic [15:0] ADDR_LINK2_FCS = 16'h091C;
  localparam logic [15:0] ADDR_LINK3_FCS = 16'h092C;
  localparam logic [15:0] ADDR_BLOCK_SUM = 16'h0B00;
  localparam logic [15:0] ADDR_CLK_CFG = 16'h0100;

  // source status registers whose reads retire summary bits
  localparam logic [15:0] ADDR_SLIP_SRC = 16'h0B08;
  localparam logic [15:0] ADDR_LOOP_SRC = 16'h0B0A;
  localparam logic [15:0] ADDR_LINK_SRC0 = 16'h0B06;
  localparam logic [15:0] ADDR_LINK_SRC1 = 16'h0B16;
  localparam logic [15:0] ADDR_LINK_SRC2 = 16'h0B26;
  localparam logic [15:0] ADDR_LINK_SRC3 = 16'h0B10;
  localparam logic [15:0] ADDR_LINK_SRC4 = 16'h0B18;
  localparam logic [15:0] ADDR_LINK_SRC5 = 16'h0B28;

  // block summary bit positions
  localparam int BIT_LOOP = 6;
  localparam int BIT_CLKLOS = 5;
  localparam int BIT_ONE_SECOND_TICK = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_SLIP = 2;

  // clock-loss detection enable inside the configuration register
  localparam int BIT_CLKLOS_EN = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // one-hot hit vector over the data-link source status registers
  function automatic logic [NUM_LINK_SRC-1:0] link_src_hit(input logic [15:0] addr);
    logic [NUM_LINK_SRC-1:0] hit;
    hit = '0;
    hit[0] = (addr == ADDR_LINK_SRC0);
    hit[1] = (addr == ADDR_LINK_SRC1);
    hit[2] = (addr == ADDR_LINK_SRC2);
    hit[3] = (addr == ADDR_LINK_SRC3);
    hit[4] = (addr == ADDR_LINK_SRC4);
    hit[5] = (addr == ADDR_LINK_SRC5);
    return hit;
  endfunction

endpackage

// >>> verilog/pmc_cnt_if.sv
/*
  Carrier between the bank and one clear-on-read event counter: the event
  pulse, the clear strobe and the running count.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps

interface pmc_cnt_if #(
  parameter int W = 8
);
  logic evt;
  logic clr;
  logic [W-1:0] cnt;

  // counter side
  modport cnt_mp(input evt, input clr, output cnt);
  // bank side
  modport use_mp(output evt, output clr, input cnt);
endinterface

// >>> verilog/pmc_rc_count.sv
/*
  Saturating event counter that restarts on a clear strobe; an event in
  the clearing cycle counts as the first of the new interval.
  Assumes event and clear are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps

module pmc_rc_count #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // counter carrier
  pmc_cnt_if.cnt_mp cnt_io
);

  localparam logic [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // restart keeps a coincident event, otherwise count up and hold at max
  always_comb begin
    if (cnt_io.clr) begin
      nxt_cnt = cnt_io.evt ? CNT_ONE : '0;
    end else if (cnt_io.evt && (cnt_ff != CNT_MAX)) begin
      nxt_cnt = cnt_ff + CNT_ONE;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // count register
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt_io.cnt = cnt_ff;

endmodule

// >>> verilog/pmc_pend_flags.sv
/*
  Vector of sticky pending flags: set by a request pulse, retired by a
  clear strobe, with the set winning when both come together.
  Assumes synchronous one-cycle pulses on both inputs.
*/
`timescale 1ns/1ps

module pmc_pend_flags #(
  parameter int N = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // set and clear strobes
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  // pending flags
  output logic [N-1:0] pend_o
);

  logic [N-1:0] pend_ff;
  logic [N-1:0] nxt_pend;

  // set beats clear in the same cycle
  always_comb begin
    nxt_pend = set_i | (pend_ff & ~clr_i);
  end

  // flag registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  assign pend_o = pend_ff;

endmodule

// >>> bench/pmc_host_model.sv
/*
  Host microprocessor model for the status bank: single reads and writes
  on the bank's strobe bus, and the ordered pair read of the 16-bit count.
  Assumes the bank takes a strobe at a rising edge and answers one cycle on.
*/
`timescale 1ns/1ps

module pmc_host_model
  import pmc_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // register bus towards the bank
  output logic [ADDR_W-1:0] mp_addr_o,
  output logic mp_rd_o,
  output logic mp_wr_o,
  output logic [DATA_W-1:0] mp_wdata_o,
  input wire logic [DATA_W-1:0] mp_rdata_i,
  input wire logic mp_rvalid_i
);
  // idle bus from time zero
  initial begin
    mp_addr_o = 16'h0000;
    mp_rd_o = 1'b0;
    mp_wr_o = 1'b0;
    mp_wdata_o = 8'h00;
  end

  // one read, answer taken in the cycle after the strobe edge
  task automatic rd(input logic [15:0] addr, output logic [7:0] data, output logic vld);
    @(negedge sys_clk_i);
    mp_addr_o = addr;
    mp_rd_o = 1'b1;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    mp_rd_o = 1'b0;
    mp_addr_o = ~addr; // released address no longer meaningful
    data = mp_rdata_i;
    vld = mp_rvalid_i;
  endtask

  // one write, no answer
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    mp_addr_o = addr;
    mp_wdata_o = data;
    mp_wr_o = 1'b1;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    mp_wr_o = 1'b0;
    mp_addr_o = ~addr;
    mp_wdata_o = ~data;
  endtask

  task automatic rd_pair(output logic [15:0] cnt, output logic vld);
    logic [7:0] hi;
    logic [7:0] lo;
    logic v1;
    logic v2;
    rd(ADDR_ZV_HIGH, hi, v1);
    rd(ADDR_ZV_LOW, lo, v2);
    cnt = {hi, lo};
    vld = v1 & v2;
  endtask
endmodule

// >>> bench/pmc_status_bank_tb.sv
/*
  Self-checking bench for the status bank: counters, clear-on-read,
  held low byte, clock-loss enable and the block summary byte.
  Assumes the host model drives the bus and this module drives events.
*/
`timescale 1ns/1ps

module pmc_status_bank_tb
  import pmc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic [10:0] ev = 11'h000; // zv, l2, l3, loop, slip, six link sources
  logic clk_lost = 1'b0;
  logic one_sec = 1'b0;
  logic clk_en;
  logic [15:0] cnt;
  logic [7:0] d;
  logic v;
  int err_total = 0;
  int checks_done = 0;
  logic [15:0] rst_tab [7] = '{ADDR_ZV_HIGH, ADDR_ZV_LOW, ADDR_LINK2_FCS, ADDR_LINK3_FCS,
                               ADDR_BLOCK_SUM, ADDR_CLK_CFG, 16'h0123};
  logic [15:0] src_tab [6] = '{ADDR_LINK_SRC0, ADDR_LINK_SRC1, ADDR_LINK_SRC2,
                               ADDR_LINK_SRC3, ADDR_LINK_SRC4, ADDR_LINK_SRC5};

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  pmc_host_model i_pmc_host_model (.sys_clk_i(sys_clk), .mp_addr_o(addr), .mp_rd_o(rd),
    .mp_wr_o(wr), .mp_wdata_o(wdata), .mp_rdata_i(rdata), .mp_rvalid_i(rvalid));

  pmc_status_bank i_pmc_status_bank (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .mp_addr_i(addr), .mp_rd_i(rd), .mp_wr_i(wr), .mp_wdata_i(wdata),
    .mp_rdata_o(rdata), .mp_rvalid_o(rvalid), .zero_violation_i(ev[0]),
    .link2_fcs_error_i(ev[1]), .link3_fcs_error_i(ev[2]), .loopback_code_req_i(ev[3]),
    .recovered_clock_lost_i(clk_lost), .one_second_tick_i(one_sec),
    .link_req_i(ev[10:5]), .slip_req_i(ev[4]), .clk_loss_detect_en_o(clk_en));

  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read one register and compare answer and strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    i_pmc_host_model.rd(a, d, v);
    chk({what, " valid"}, 16'h0001, {15'h0000, v});
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask

  // n one-cycle pulses on the selected event lines
  task automatic pulse(input logic [10:0] m, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      ev = m;
      @(negedge sys_clk);
      ev = 11'h000;
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of about 1300 cycles
  initial begin
    #400000;
    err_total++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    arst_n = 1'b1;
    // reset values, unmapped address last
    foreach (rst_tab[i]) rd_chk(rst_tab[i], 8'h00, "reset value");
    // frame check counters, separate and clear on read
    pulse(11'h002, 5);
    pulse(11'h004, 9);
    rd_chk(ADDR_LINK2_FCS, 8'h05, "link2 count");
    rd_chk(ADDR_LINK2_FCS, 8'h00, "link2 after read");
    rd_chk(ADDR_LINK3_FCS, 8'h09, "link3 count");
    rd_chk(ADDR_LINK3_FCS, 8'h00, "link3 after read");
    // an error in the clearing cycle starts the new interval at one
    fork
      pulse(11'h004, 1);
      rd_chk(ADDR_LINK3_FCS, 8'h00, "link3 read with error");
    join
    rd_chk(ADDR_LINK3_FCS, 8'h01, "link3 error kept at clear");
    pulse(11'h002, 260);
    rd_chk(ADDR_LINK2_FCS, 8'hFF, "link2 saturated");
    // zero violation count across both bytes
    pulse(11'h001, 300);
    i_pmc_host_model.rd_pair(cnt, v);
    chk("zero violation count", 16'h012C, cnt);
    i_pmc_host_model.rd_pair(cnt, v);
    chk("zero violation cleared", 16'h0000, cnt);
    // held low byte survives events after the upper read
    pulse(11'h001, 2);
    rd_chk(ADDR_ZV_HIGH, 8'h00, "upper byte");
    pulse(11'h001, 3);
    rd_chk(ADDR_ZV_LOW, 8'h02, "held low byte");
    i_pmc_host_model.rd_pair(cnt, v);
    chk("events after hold", 16'h0003, cnt);
    // a low read with no hold shows the live byte and clears the count
    pulse(11'h001, 4);
    rd_chk(ADDR_ZV_LOW, 8'h04, "unheld low byte");
    i_pmc_host_model.rd_pair(cnt, v);
    chk("unheld low read cleared", 16'h0000, cnt);
    // clock loss only shows once detection is enabled
    @(negedge sys_clk);
    clk_lost = 1'b1;
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary clock loss off");
    i_pmc_host_model.wr(ADDR_CLK_CFG, 8'h01);
    chk("clock loss enable", 16'h0001, {15'h0000, clk_en});
    rd_chk(ADDR_CLK_CFG, 8'h01, "config readback");
    i_pmc_host_model.wr(ADDR_BLOCK_SUM, 8'h00);
    rd_chk(ADDR_CLK_CFG, 8'h01, "config after stray write");
    rd_chk(ADDR_BLOCK_SUM, 8'h20, "summary clock loss");
    clk_lost = 1'b0;
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary clock back");
    // one-second level follows its source
    one_sec = 1'b1;
    rd_chk(ADDR_BLOCK_SUM, 8'h10, "summary one second");
    one_sec = 1'b0;
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary one second off");
    // loopback and slip flags retire on their own source reads
    // summary read in the cycle right after the requests
    fork
      pulse(11'h018, 1);
      begin
        @(negedge sys_clk);
        rd_chk(ADDR_BLOCK_SUM, 8'h44, "summary loop and slip");
      end
    join
    rd_chk(ADDR_LOOP_SRC, 8'h00, "loop source");
    rd_chk(ADDR_BLOCK_SUM, 8'h04, "summary after loop read");
    rd_chk(ADDR_SLIP_SRC, 8'h00, "slip source");
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary after slip read");
    // a request in the cycle of its source read keeps the flag
    fork
      pulse(11'h010, 1);
      rd_chk(ADDR_SLIP_SRC, 8'h00, "slip source at request");
    join
    rd_chk(ADDR_BLOCK_SUM, 8'h04, "summary slip set wins");
    rd_chk(ADDR_SLIP_SRC, 8'h00, "slip source again");
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary slip retired");
    // a source that did not raise the request leaves it pending
    pulse(11'h100, 1);
    rd_chk(ADDR_LINK_SRC0, 8'h00, "other link source");
    rd_chk(ADDR_BLOCK_SUM, 8'h08, "summary link kept");
    rd_chk(ADDR_LINK_SRC3, 8'h00, "raising link source");
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary link cleared");
    // all six pending, bit stays until the last is read
    pulse(11'h7E0, 1);
    foreach (src_tab[k]) begin
      rd_chk(ADDR_BLOCK_SUM, 8'h08, "summary link pending");
      rd_chk(src_tab[k], 8'h00, "link source");
    end
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary all links read");
    // raising source read in the cycle right after its request
    fork
      pulse(11'h020, 1);
      begin
        @(negedge sys_clk);
        rd_chk(ADDR_LINK_SRC0, 8'h00, "link source after request");
      end
    join
    rd_chk(ADDR_BLOCK_SUM, 8'h00, "summary link retired fast");
    stop_test();
  end
endmodule
